// ===== dv/lldf_ctl_model.sv
// Purpose: memory controller model on the command pins
// Assumes: caller starts each send just after a clock edge
// Notes: idle pins carry inverted values, never the last command
`timescale 1ns/1ps
module lldf_ctl_model import lldf_pkg::*; #(
  parameter int RC_CYC = 8,
  parameter int MRS_WAIT = 6
) (
  input wire logic core_clk,
  input wire logic muxOn,
  output lldf_cmd_t cmdCode,
  output logic [2:0] bankSel,
  output logic [20:0] addrPins
);
  int cyc = 0;
  int allFree = 0;
  int arefSent = 0;
  int bankFree [8];
  initial begin
    cmdCode = LLDF_NOP;
    bankSel = 3'h0;
    addrPins = 21'h0;
  end
  always @(posedge core_clk) cyc <= cyc + 1;
  function automatic logic [20:0] pins(input lldf_cmd_t c, input logic [20:0] a);
    logic [20:0] r;
    r = a;
    if (muxOn) r = (r & 21'h066739) | ~21'h066739;
    // mode load high bits, after filler so they stay low
    if (c == LLDF_MRS) r[17:10] = 8'h00;
    return r;
  endfunction
  task automatic send(input lldf_cmd_t c, input logic [2:0] b, input logic [20:0] x,
      input logic [20:0] y, input logic two, input lldf_cmd_t c2 = LLDF_NOP);
    for (int i = 0; i < 200 && (cyc < bankFree[b] || cyc < allFree); i++) @(posedge core_clk);
    @(posedge core_clk);
    cmdCode <= c;
    bankSel <= b;
    addrPins <= pins(c, x);
    if (two) begin
      @(posedge core_clk);
      cmdCode <= c2;
      bankSel <= ~b;
      addrPins <= pins(c, y);
    end
    @(posedge core_clk);
    cmdCode <= LLDF_NOP;
    bankSel <= ~bankSel;
    addrPins <= ~addrPins;
    if (c == LLDF_AUTO_REFRESH_CMD) bankFree[b] = cyc + RC_CYC;
    if (c2 == LLDF_AUTO_REFRESH_CMD) bankFree[~b] = cyc + RC_CYC;
    // refreshes issued, spread or in bursts
    arefSent += int'(c == LLDF_AUTO_REFRESH_CMD) + int'(c2 == LLDF_AUTO_REFRESH_CMD);
    if (c == LLDF_MRS) allFree = cyc + MRS_WAIT;
  endtask
endmodule

// ===== dv/lldf_front_properties.sv
// Purpose: port checks of the command front end
// Assumes: bound to every lldf_front instance
// Notes: single clock domain
`timescale 1ns/1ps
module lldf_front_chk import lldf_pkg::*; #(
  parameter int BANKS = 8
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire lldf_cmd_t cmdCode,
  input wire logic [$clog2(BANKS)-1:0] bankSel,
  input wire logic [20:0] addrPins,
  input wire logic accessStrobe,
  input wire logic accessWrite,
  input wire logic [$clog2(BANKS)-1:0] accessBank,
  input wire logic [20:0] accessAddr,
  input wire logic [3:0] readLatency,
  input wire logic [3:0] writeLatency,
  input wire logic refreshStrobe,
  input wire logic [$clog2(BANKS)-1:0] refreshBank,
  input wire logic dataTermOn,
  input wire logic muxModeActive,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic isAccess;
  assign isAccess = cmdCode == LLDF_RD || cmdCode == LLDF_WR;
  property p_acc_direct;
    isAccess && !muxModeActive |=> accessStrobe && accessBank == $past(bankSel)
      && accessAddr == $past(addrPins) && accessWrite == $past(cmdCode == LLDF_WR);
  endproperty
  a_acc_direct: assert property (p_acc_direct) else $error("direct access wrong");
  property p_acc_mux;
    isAccess && muxModeActive |=> !accessStrobe ##1 accessStrobe
      && accessBank == $past(bankSel, 2);
  endproperty
  a_acc_mux: assert property (p_acc_mux) else $error("two-part access wrong");
  property p_auto_refresh_cmd_direct;
    cmdCode == LLDF_AUTO_REFRESH_CMD && !muxModeActive |-> ##1 refreshStrobe
      && refreshBank == $past(bankSel);
  endproperty
  a_auto_refresh_cmd_direct: assert property (p_auto_refresh_cmd_direct) else $error("refresh wrong");
  property p_auto_refresh_cmd_mux;
    cmdCode == LLDF_AUTO_REFRESH_CMD && muxModeActive |-> ##2 refreshStrobe
      && refreshBank == $past(bankSel, 2);
  endproperty
  a_auto_refresh_cmd_mux: assert property (p_auto_refresh_cmd_mux) else $error("mux refresh wrong");
  property p_wl_rl;
    readLatency != 4'h0 |-> writeLatency == readLatency + 4'h1;
  endproperty
  a_wl_rl: assert property (p_wl_rl) else $error("write latency wrong");
  property p_term_read;
    accessStrobe && !accessWrite && dataTermOn |=> !dataTermOn;
  endproperty
  a_term_read: assert property (p_term_read) else $error("termination kept");
  property p_ref_cause;
    refreshStrobe |-> $past(cmdCode) == LLDF_AUTO_REFRESH_CMD || $past(cmdCode, 2) == LLDF_AUTO_REFRESH_CMD;
  endproperty
  a_ref_cause: assert property (p_ref_cause) else $error("stray refresh");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken early");
endmodule
bind lldf_front lldf_front_chk #(.BANKS(BANKS)) u_chk (.core_clk, .rst_b, .cmdCode,
  .bankSel, .addrPins, .accessStrobe, .accessWrite, .accessBank, .accessAddr, .readLatency,
  .writeLatency, .refreshStrobe, .refreshBank, .dataTermOn, .muxModeActive, .s_axi_arready,
  .s_axi_rvalid);

// ===== dv/tb_top.sv
// Purpose: self-checking bench of the command front end
// Assumes: controller model drives the command pins
// Notes: x18 width, so second-part A10 carries bit 19 at burst two
`timescale 1ns/1ps
module tb_top import lldf_pkg::*; ;
  typedef struct {logic two; logic [20:0] x; logic [20:0] y; logic [3:0] rl; logic [3:0] wl;
    logic mux;} lldf_row_t;
  logic core_clk = 1'b0, rst_b = 1'b0, muxCfg = 1'b0;
  lldf_cmd_t cmdCode;
  logic [2:0] bankSel, accessBank, refreshBank;
  logic [20:0] addrPins, accessAddr, exp;
  logic [3:0] readLatency, writeLatency;
  logic [12:0] refreshRow;
  logic accessStrobe, accessWrite, refreshStrobe, dataTermOn, maskTermOn, muxModeActive;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp, bl;
  logic [15:0] refLog [$];
  logic [15:0] expLog [6] = '{16'h6000, 16'h6001, 16'hA000, 16'hC000, 16'h2000, 16'h6000};
  lldf_row_t rows [7] = '{'{1'b0, 21'h1, 21'h0, 4'h4, 4'h5, 1'b0},
    '{1'b0, 21'h2, 21'h0, 4'h6, 4'h7, 1'b0}, '{1'b0, 21'h3, 21'h0, 4'h8, 4'h9, 1'b0},
    '{1'b0, 21'h21, 21'h0, 4'h5, 4'h6, 1'b1}, '{1'b1, 21'h20, 21'h8, 4'h7, 4'h8, 1'b1},
    '{1'b1, 21'h21, 21'h8, 4'h9, 4'hA, 1'b1}, '{1'b1, 21'h1, 21'h0, 4'h4, 4'h5, 1'b0}};
  int miscompares = 0, checked = 0, n;
  initial forever #2.5 core_clk = ~core_clk;
  lldf_front #(.DATA_W(18)) uut (.core_clk, .rst_b, .cmdCode, .bankSel, .addrPins,
    .accessStrobe, .accessWrite, .accessBank, .accessAddr, .readLatency, .writeLatency,
    .refreshStrobe, .refreshBank, .refreshRow, .dataTermOn, .maskTermOn, .muxModeActive,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  lldf_ctl_model ctl (.core_clk, .muxOn(muxCfg), .cmdCode, .bankSel, .addrPins);
  always @(posedge core_clk) if (refreshStrobe === 1'b1) refLog.push_back({refreshBank, refreshRow});
  function automatic logic [20:0] mmap(input logic [20:0] x, input logic [20:0] y,
      input logic [1:0] b);
    return {1'b0, y[10] & (b == 2'h0), x[18] & (b != 2'h2), x[17], y[17], y[18], x[14], x[13],
      y[14], y[13], x[10], x[9], x[8], y[9], y[8], x[5], x[4], x[3], y[4], y[3], x[0]};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want) begin
      miscompares++;
      $display("ERROR %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic hang();
    miscompares++;
    $display("ERROR %0t wait ran out", $time);
    tally_and_finish();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i <= 50; i++) begin
      if (i == 50) hang();
      @(posedge core_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        rsp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i <= 50; i++) begin
      if (i == 50) hang();
      @(posedge core_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  // Counts cycles without data termination
  task automatic count_off();
    n = 0;
    for (int i = 0; i < 30; i++) begin
      @(posedge core_clk);
      #1;
      if (dataTermOn !== 1'b1) n++;
    end
  endtask
  initial begin
    #100000;
    hang();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    cmp({awready, wready, arready, accessStrobe, refreshStrobe, dataTermOn, readLatency}, 10'h380);
    @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    cmp({readLatency, writeLatency}, 8'h23);
    axi_rd(8'h0C);
    cmp(rd, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      muxCfg = rows[i].two;
      ctl.send(LLDF_MRS, 3'h0, rows[i].x, rows[i].y, rows[i].two);
      exp = rows[i].two ? mmap(rows[i].x, rows[i].y, 2'h0) : rows[i].x;
      repeat (3) @(posedge core_clk);
      #1;
      cmp({readLatency, writeLatency}, {rows[i].rl, rows[i].wl});
      cmp(muxModeActive, rows[i].mux);
      axi_rd(8'h00);
      cmp(rd, exp[17:0]);
    end
    muxCfg = 1'b0;
    $display("test mode table done");
    ctl.send(LLDF_MRS, 3'h0, 21'h209, 21'h0, 1'b0);
    repeat (3) @(posedge core_clk);
    #1;
    cmp({dataTermOn, maskTermOn}, 2'h3);
    axi_rd(8'h04);
    cmp(rd, 32'h1);
    ctl.send(LLDF_RD, 3'h2, 21'h1ABCDE, 21'h0, 1'b0);
    #1;
    cmp({accessStrobe, accessWrite, accessBank, accessAddr}, {5'h12, 21'h1ABCDE});
    count_off();
    cmp(n, 32'h6);
    ctl.send(LLDF_WR, 3'h2, 21'h0, 21'h0, 1'b0);
    count_off();
    cmp(n, 32'h0);
    axi_wr(8'h08, 32'h1);
    cmp(rsp, 2'h0);
    axi_rd(8'h08);
    cmp(rd, 32'h1);
    cmp(dataTermOn, 1'b0);
    axi_wr(8'h08, 32'h0);
    axi_wr(8'h00, 32'h3FFFF);
    cmp(rsp, 2'h2);
    cmp(dataTermOn, 1'b1);
    axi_rd(8'h00);
    cmp(rd, 32'h209);
    axi_rd(8'h10);
    cmp(rsp, 2'h2);
    cmp(rd, 32'h0);
    $display("test termination done");
    ctl.send(LLDF_AUTO_REFRESH_CMD, 3'h3, 21'h1FFFFF, 21'h0, 1'b0);
    ctl.send(LLDF_AUTO_REFRESH_CMD, 3'h3, 21'h0, 21'h0, 1'b0);
    ctl.send(LLDF_AUTO_REFRESH_CMD, 3'h5, 21'h0, 21'h0, 1'b0);
    ctl.send(LLDF_MRS, 3'h0, 21'h22, 21'h0, 1'b0);
    muxCfg = 1'b1;
    for (int k = 0; k < 2; k++) begin
      bl = k ? 2'h2 : 2'h0;
      if (k) ctl.send(LLDF_MRS, 3'h0, 21'h30, 21'h8, 1'b1);
      ctl.send(LLDF_WR, 3'h4, 21'h0A5A5A, 21'h15A5A5, 1'b1);
      #1;
      cmp({accessStrobe, accessWrite, accessBank}, 5'h1C);
      cmp(accessAddr, mmap(21'h0A5A5A, 21'h15A5A5, bl));
    end
    ctl.send(LLDF_AUTO_REFRESH_CMD, 3'h6, 21'h0, 21'h0, 1'b1, LLDF_AUTO_REFRESH_CMD);
    repeat (6) @(posedge core_clk);
    axi_rd(8'h0C);
    cmp(rd, ctl.arefSent);
    $display("test refresh and mux done");
    rst_b <= 1'b0;
    muxCfg = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    cmp({muxModeActive, dataTermOn, readLatency, refreshRow}, 19'h0);
    @(posedge core_clk);
    rst_b <= 1'b1;
    ctl.send(LLDF_AUTO_REFRESH_CMD, 3'h3, 21'h0, 21'h0, 1'b0);
    repeat (4) @(posedge core_clk);
    cmp(refLog.size(), 32'h6);
    foreach (expLog[i]) cmp(refLog[i], expLog[i]);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule

// ===== logic/lldf_front.sv
// Purpose: command and address front end: refresh, termination, multiplexed address
// Assumes: command pins are launched by the controller on core_clk
// Notes: registers over AXI4-Lite; all accesses answered, unmapped reads and writes to any register but control with SLVERR
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "lldf_map.svh"

// Function
// - Auto refresh refreshes one row of addressed bank from internal counter
// - Termination enabled when A9 is one at mode load, else off
// - Only data and write mask inputs are terminated, never command or clock
// - Termination off during reads, back on after last read beat
// - Multiplexed mode: address latched in two parts on consecutive edges
// - Multiplexed mode entered when A5 is loaded as one
// - In multiplexed mode read, write and mode load use two parts
// - Second part lines carry bits 1,2,6,7,11,12,16,15; first part as named
// - Second-part A0 and A10, first-part A18 usage depends on width and burst
// - Second-part line A5 is ignored
// - Multiplexed latencies one longer: read 5/7/9, write 6/8/10
// - Multiplexed auto refresh runs next edge, next command on following clock
// - Mode load stores address inputs 17 to 0 as the configuration
module lldf_front import lldf_pkg::*; #(
  parameter int DATA_W = 36,
  parameter int ROW_W = 13,
  parameter int BANKS = 8
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire lldf_cmd_t cmdCode,
  input wire logic [$clog2(BANKS)-1:0] bankSel,
  input wire logic [20:0] addrPins,
  output logic accessStrobe,
  output logic accessWrite,
  output logic [$clog2(BANKS)-1:0] accessBank,
  output logic [20:0] accessAddr,
  output logic [3:0] readLatency,
  output logic [3:0] writeLatency,
  output logic refreshStrobe,
  output logic [$clog2(BANKS)-1:0] refreshBank,
  output logic [ROW_W-1:0] refreshRow,
  output logic dataTermOn,
  output logic maskTermOn,
  output logic muxModeActive,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int BW = $clog2(BANKS);
  localparam bit IS9 = (DATA_W == 9);
  localparam bit IS18 = (DATA_W == 18);
  localparam bit IS36 = (DATA_W == 36);

  // Register index decode, shared by the read and write paths
  function automatic logic [2:0] regDecode(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    case (w)
      `LLDF_OFF_MODE: regDecode = 3'h4;
      `LLDF_OFF_STATUS: regDecode = 3'h5;
      `LLDF_OFF_CTRL: regDecode = 3'h6;
      `LLDF_OFF_REFCNT: regDecode = 3'h7;
      default: regDecode = 3'h0;
    endcase
  endfunction

  // Joins the two address parts; bl is the burst field of the mode word
  function automatic logic [20:0] muxJoin(input logic [18:0] f, input logic [18:0] s,
                                         input logic [1:0] bl);
    logic [20:0] a;
    logic bl2;
    logic bl4;
    logic bl8;
    a = '0;
    bl2 = (bl == 2'h0);
    bl4 = (bl == 2'h1);
    bl8 = (bl == 2'h2);
    a[0] = f[0];
    a[3] = f[3];
    a[4] = f[4];
    a[5] = f[5];
    a[8] = f[8];
    a[9] = f[9];
    a[10] = f[10];
    a[13] = f[13];
    a[14] = f[14];
    a[17] = f[17];
    a[1] = s[3];
    a[2] = s[4];
    a[6] = s[8];
    a[7] = s[9];
    a[11] = s[13];
    a[12] = s[14];
    a[16] = s[17];
    a[15] = s[18];
    a[18] = ((IS36 && bl4) || (IS18 && bl8)) ? 1'b0 : f[18];
    a[19] = ((IS18 && bl2) || (IS9 && (bl2 || bl4))) ? s[10] : 1'b0;
    a[20] = (IS9 && bl2) ? s[0] : 1'b0;
    muxJoin = a;
  endfunction

  // Front end state
  lldf_fe_t feState_q, feState_d;
  lldf_cmd_t cmdHeld_q, cmdHeld_d;
  logic [BW-1:0] bankHeld_q, bankHeld_d;
  logic [18:0] firstHeld_q, firstHeld_d;
  logic [`LLDF_MODE_W-1:0] modeWord_q, modeWord_d;
  logic accStrobe_q, accStrobe_d;
  logic accWrite_q, accWrite_d;
  logic [BW-1:0] accBank_q, accBank_d;
  logic [20:0] accAddr_q, accAddr_d;
  logic arefPend_q, arefPend_d;
  logic [BW-1:0] pendBank_q, pendBank_d;
  logic arefGo;
  logic [BW-1:0] arefBank;
  logic muxOn;
  logic [20:0] joined;

  assign muxOn = modeWord_q[`LLDF_MODE_MUX_BIT];
  assign joined = muxJoin(firstHeld_q, addrPins[18:0],
                          modeWord_q[`LLDF_MODE_BL_MSB:`LLDF_MODE_BL_LSB]);

  always_comb begin
    feState_d = feState_q;
    cmdHeld_d = cmdHeld_q;
    bankHeld_d = bankHeld_q;
    firstHeld_d = firstHeld_q;
    modeWord_d = modeWord_q;
    accStrobe_d = 1'b0;
    accWrite_d = accWrite_q;
    accBank_d = accBank_q;
    accAddr_d = accAddr_q;
    arefPend_d = 1'b0;
    pendBank_d = pendBank_q;
    arefGo = 1'b0;
    arefBank = bankSel;
    // deferred refresh runs one edge later
    if (arefPend_q) begin
      arefGo = 1'b1;
      arefBank = pendBank_q;
    end
    case (feState_q)
      LLDF_FE_CMD: begin
        case (cmdCode)
          LLDF_RD, LLDF_WR, LLDF_MRS: begin
            if (muxOn) begin
              feState_d = LLDF_FE_SECOND;
              cmdHeld_d = cmdCode;
              bankHeld_d = bankSel;
              firstHeld_d = addrPins[18:0];
            end else if (cmdCode == LLDF_MRS) begin
              modeWord_d = addrPins[`LLDF_MODE_W-1:0];
            end else begin
              accStrobe_d = 1'b1;
              accWrite_d = (cmdCode == LLDF_WR);
              accBank_d = bankSel;
              accAddr_d = addrPins;
            end
          end
          LLDF_AUTO_REFRESH_CMD: begin
            if (muxOn) begin
              arefPend_d = 1'b1;
              pendBank_d = bankSel;
            end else begin
              arefGo = 1'b1;
              arefBank = bankSel;
            end
          end
          default: begin
          end
        endcase
      end
      LLDF_FE_SECOND: begin
        feState_d = LLDF_FE_CMD;
        if (cmdHeld_q == LLDF_MRS) begin
          modeWord_d = joined[`LLDF_MODE_W-1:0];
        end else begin
          accStrobe_d = 1'b1;
          accWrite_d = (cmdHeld_q == LLDF_WR);
          accBank_d = bankHeld_q;
          accAddr_d = joined;
        end
      end
      default: feState_d = LLDF_FE_CMD;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      feState_q <= LLDF_FE_CMD;
      cmdHeld_q <= LLDF_NOP;
      bankHeld_q <= '0;
      firstHeld_q <= '0;
      modeWord_q <= `LLDF_MODE_RST;
      accStrobe_q <= 1'b0;
      accWrite_q <= 1'b0;
      accBank_q <= '0;
      accAddr_q <= '0;
      arefPend_q <= 1'b0;
      pendBank_q <= '0;
    end else begin
      feState_q <= feState_d;
      cmdHeld_q <= cmdHeld_d;
      bankHeld_q <= bankHeld_d;
      firstHeld_q <= firstHeld_d;
      modeWord_q <= modeWord_d;
      accStrobe_q <= accStrobe_d;
      accWrite_q <= accWrite_d;
      accBank_q <= accBank_d;
      accAddr_q <= accAddr_d;
      arefPend_q <= arefPend_d;
      pendBank_q <= pendBank_d;
    end
  end

  assign accessStrobe = accStrobe_q;
  assign accessWrite = accWrite_q;
  assign accessBank = accBank_q;
  assign accessAddr = accAddr_q;

  // Latency and termination state
  logic [3:0] rdLat_q, rdLat_d;
  logic [3:0] wrLat_q, wrLat_d;
  logic [4:0] termCnt_q, termCnt_d;
  logic termOn_q, termOn_d;
  logic ctrlInhibit_q, ctrlInhibit_d;
  logic [2:0] beats;

  always_comb begin
    case (modeWord_q[`LLDF_MODE_BL_MSB:`LLDF_MODE_BL_LSB])
      2'h1: beats = 3'h2;
      2'h2: beats = 3'h4;
      default: beats = 3'h1;
    endcase
    // latency per configuration, one more when multiplexed
    rdLat_d = 4'({1'b0, modeWord_q[`LLDF_MODE_CFG_MSB:`LLDF_MODE_CFG_LSB]} << 1)
              + `LLDF_RL_OFFSET + (muxOn ? `LLDF_MUX_EXTRA : 4'h0);
    wrLat_d = rdLat_d + `LLDF_WL_EXTRA;
    termCnt_d = termCnt_q;
    // read holds termination off through its last beat
    if (accStrobe_q && !accWrite_q) begin
      termCnt_d = 5'(rdLat_q) + 5'(beats);
    end else if (termCnt_q != 5'h00) begin
      termCnt_d = termCnt_q - 5'h01;
    end
    termOn_d = modeWord_q[`LLDF_MODE_ODT_BIT] && !ctrlInhibit_q && (termCnt_d == 5'h00);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdLat_q <= '0;
      wrLat_q <= '0;
      termCnt_q <= '0;
      termOn_q <= 1'b0;
    end else begin
      rdLat_q <= rdLat_d;
      wrLat_q <= wrLat_d;
      termCnt_q <= termCnt_d;
      termOn_q <= termOn_d;
    end
  end

  assign readLatency = rdLat_q;
  assign writeLatency = wrLat_q;
  assign dataTermOn = termOn_q;
  assign maskTermOn = termOn_q;
  assign muxModeActive = muxOn;

  // Refresh state
  logic refStrobe_q, refStrobe_d;
  logic [BW-1:0] refBank_q, refBank_d;
  logic [31:0] refCount_q, refCount_d;
  logic [ROW_W-1:0] rowNow;

  always_comb begin
    // row taken from the bank counter
    refStrobe_d = arefGo;
    refBank_d = arefGo ? arefBank : refBank_q;
    refCount_d = refCount_q + {31'h0, refStrobe_q};
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      refStrobe_q <= 1'b0;
      refBank_q <= '0;
      refCount_q <= `LLDF_REFCNT_RST;
    end else begin
      refStrobe_q <= refStrobe_d;
      refBank_q <= refBank_d;
      refCount_q <= refCount_d;
    end
  end

  // Same-bank back to back is barred by row cycle, so ports never collide
  lldf_row_mem #(.DEPTH(BANKS), .WIDTH(ROW_W)) rowMem (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .rdAddr(arefBank),
    .rdData(rowNow),
    .wrEn(refStrobe_q),
    .wrAddr(refBank_q),
    .wrData(rowNow + ROW_W'(1))
  );

  assign refreshStrobe = refStrobe_q;
  assign refreshBank = refBank_q;
  assign refreshRow = rowNow;

  // Register bus slave
  logic awHave_q, awHave_d;
  logic wHave_q, wHave_d;
  logic [7:0] awAddr_q, awAddr_d;
  logic wBit_q, wBit_d;
  logic wStrb0_q, wStrb0_d;
  logic bValid_q, bValid_d;
  logic [1:0] bResp_q, bResp_d;
  logic rValid_q, rValid_d;
  logic [31:0] rData_q, rData_d;
  logic [1:0] rResp_q, rResp_d;
  logic [2:0] wSel;
  logic [2:0] rSel;

  assign s_axi_awready = !awHave_q && !bValid_q;
  assign s_axi_wready = !wHave_q && !bValid_q;
  assign s_axi_arready = !rValid_q;
  assign wSel = regDecode(awAddr_q);
  assign rSel = regDecode(s_axi_araddr);

  always_comb begin
    awHave_d = awHave_q;
    wHave_d = wHave_q;
    awAddr_d = awAddr_q;
    wBit_d = wBit_q;
    wStrb0_d = wStrb0_q;
    bValid_d = bValid_q;
    bResp_d = bResp_q;
    ctrlInhibit_d = ctrlInhibit_q;
    rValid_d = rValid_q;
    rData_d = rData_q;
    rResp_d = rResp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      awHave_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHave_d = 1'b1;
      wBit_d = s_axi_wdata[`LLDF_CTRL_INHIBIT_BIT];
      wStrb0_d = s_axi_wstrb[0];
    end
    // Commit once both halves are held
    if (awHave_q && wHave_q) begin
      awHave_d = 1'b0;
      wHave_d = 1'b0;
      bValid_d = 1'b1;
      bResp_d = (wSel == 3'h6) ? `LLDF_RESP_OKAY : `LLDF_RESP_SLVERR;
      if (wSel == 3'h6 && wStrb0_q) begin
        ctrlInhibit_d = wBit_q;
      end
    end
    if (bValid_q && s_axi_bready) begin
      bValid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rValid_d = 1'b1;
      rResp_d = rSel[2] ? `LLDF_RESP_OKAY : `LLDF_RESP_SLVERR;
      case (rSel)
        3'h4: rData_d = {14'h0000, modeWord_q};
        3'h5: rData_d = {29'h0, termCnt_q != 5'h00, muxOn, termOn_q};
        3'h6: rData_d = {31'h0, ctrlInhibit_q};
        3'h7: rData_d = refCount_q;
        default: rData_d = 32'h0000_0000;
      endcase
    end
    if (rValid_q && s_axi_rready) begin
      rValid_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= '0;
      wBit_q <= 1'b0;
      wStrb0_q <= 1'b0;
      bValid_q <= 1'b0;
      bResp_q <= `LLDF_RESP_OKAY;
      ctrlInhibit_q <= `LLDF_CTRL_RST;
      rValid_q <= 1'b0;
      rData_q <= '0;
      rResp_q <= `LLDF_RESP_OKAY;
    end else begin
      awHave_q <= awHave_d;
      wHave_q <= wHave_d;
      awAddr_q <= awAddr_d;
      wBit_q <= wBit_d;
      wStrb0_q <= wStrb0_d;
      bValid_q <= bValid_d;
      bResp_q <= bResp_d;
      ctrlInhibit_q <= ctrlInhibit_d;
      rValid_q <= rValid_d;
      rData_q <= rData_d;
      rResp_q <= rResp_d;
    end
  end

  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;
endmodule

// ===== logic/lldf_map.svh
// Purpose: offsets, field positions, reset values and cycle figures of the front end
// Assumes: included by bare name wherever these figures are needed
// Notes: offsets are byte addresses of 32-bit words on the register bus
`ifndef LLDF_MAP_SVH
`define LLDF_MAP_SVH

`define LLDF_OFF_MODE 8'h00
`define LLDF_OFF_STATUS 8'h04
`define LLDF_OFF_CTRL 8'h08
`define LLDF_OFF_REFCNT 8'h0C

`define LLDF_MODE_W 18
`define LLDF_MODE_CFG_LSB 0
`define LLDF_MODE_CFG_MSB 2
`define LLDF_MODE_BL_LSB 3
`define LLDF_MODE_BL_MSB 4
`define LLDF_MODE_MUX_BIT 5
`define LLDF_MODE_ODT_BIT 9
`define LLDF_CTRL_INHIBIT_BIT 0
`define LLDF_STAT_TERM_BIT 0
`define LLDF_STAT_MUX_BIT 1
`define LLDF_STAT_RDBUSY_BIT 2

`define LLDF_MODE_RST 18'h00000
`define LLDF_CTRL_RST 1'h0
`define LLDF_REFCNT_RST 32'h0000_0000

`define LLDF_RL_OFFSET 4'h2
`define LLDF_WL_EXTRA 4'h1
`define LLDF_MUX_EXTRA 4'h1

`define LLDF_RESP_OKAY 2'h0
`define LLDF_RESP_SLVERR 2'h2

`endif

// ===== logic/lldf_pkg.sv
// Purpose: types shared by the command front end
// Assumes: nothing
// Notes: command codes follow declaration order, NOP is zero
package lldf_pkg;
  typedef enum logic [2:0] {
    LLDF_NOP,
    LLDF_RD,
    LLDF_WR,
    LLDF_AUTO_REFRESH_CMD,
    LLDF_MRS
  } lldf_cmd_t;

  typedef enum logic {
    LLDF_FE_CMD,
    LLDF_FE_SECOND
  } lldf_fe_t;
endpackage

// ===== logic/lldf_row_mem.sv
// Purpose: per-bank refresh row counters
// Assumes: read and write never hit the same bank in one cycle
// Notes: read data is registered, one cycle after the address
`timescale 1ns/1ps
module lldf_row_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 13
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData,
  input wire logic wrEn,
  input wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      rdData <= '0;
    end else begin
      if (wrEn) begin
        mem_q[wrAddr] <= wrData;
      end
      rdData <= mem_q[rdAddr];
    end
  end
endmodule
